/* File: core/tca_pkg.sv */
package tca_pkg;
  // Register byte offsets on the AXI4-Lite slave
  localparam logic [4:0] TCA_OFF_TLB_CMD = 5'h00;
  localparam logic [4:0] TCA_OFF_TLB_DATA = 5'h04;
  localparam logic [4:0] TCA_OFF_C_DATA = 5'h08;
  localparam logic [4:0] TCA_OFF_C_TAG = 5'h0C;
  localparam logic [4:0] TCA_OFF_C_CTRL = 5'h10;
  localparam logic [4:0] TCA_OFF_STATUS = 5'h14;
  // Reset values
  localparam logic [31:0] TCA_RST_WORD = 32'h0000_0000;
  // Translation buffer geometry
  localparam int TCA_TLB_WAYS = 4;
  localparam int TCA_TLB_SETS = 8;
  // Command register fields
  localparam int TCA_CMD_OP = 0;
  localparam int TCA_CMD_V = 11;
  localparam int TCA_CMD_D_HI = 10;
  localparam int TCA_CMD_U_HI = 8;
  localparam int TCA_CMD_R_HI = 6;
  localparam int TCA_LIN_LO = 12;
  // Data register fields
  localparam int TCA_TD_PCD = 11;
  localparam int TCA_TD_PWT = 10;
  localparam int TCA_TD_LRU_LO = 7;
  localparam int TCA_TD_HIT = 4;
  localparam int TCA_TD_WAY_LO = 2;
  // Cache geometry and fields
  localparam int TCA_C_LINES = 128;
  localparam int TCA_CT_TAG_LO = 9;
  localparam int TCA_CT_LRU = 7;
  localparam int TCA_CT_VAL_LO = 3;
  localparam int TCA_CC_LINE_LO = 4;
  localparam int TCA_CC_WAY = 2;
  // Cache operation codes
  localparam logic [1:0] TCA_COP_NONE = 2'h0;
  localparam logic [1:0] TCA_COP_WRITE = 2'h1;
  localparam logic [1:0] TCA_COP_READ = 2'h2;
  localparam logic [1:0] TCA_COP_FLUSH = 2'h3;
  // AXI responses
  localparam logic [1:0] TCA_RESP_OK = 2'h0;
  localparam logic [1:0] TCA_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {TCA_IDLE, TCA_TLB_OP, TCA_C_OP, TCA_FLUSH} tca_state_e;
endpackage : tca_pkg

/* File: core/tca_top.sv */
// Decided for this implementation: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module tca_top
  import tca_pkg::*;
(
  input wire logic aclk, // Core clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);

  // Register file
  logic [31:0] tlb_test_command_ff;
  logic [31:0] tlb_test_data_ff;
  logic [31:0] cache_test_data_ff;
  logic [31:0] cache_test_tag_status_ff;
  logic [31:0] cache_test_control_ff;
  tca_state_e state_ff;

  // Translation buffer storage, indexed by way and set
  logic [19:0] tlb_lin_ff [TCA_TLB_WAYS][TCA_TLB_SETS];
  logic [19:0] tlb_page_ff [TCA_TLB_WAYS][TCA_TLB_SETS];
  logic [2:0] tlb_attr_ff [TCA_TLB_WAYS][TCA_TLB_SETS]; // dirty, user, rw
  logic [1:0] tlb_pc_ff [TCA_TLB_WAYS][TCA_TLB_SETS]; // cache disable, write-through
  logic tlb_val_ff [TCA_TLB_WAYS][TCA_TLB_SETS];
  logic [2:0] tlb_plru_ff [TCA_TLB_SETS];

  // Cache storage, indexed by way and line
  logic [22:0] c_tag_ff [2][TCA_C_LINES];
  logic [31:0] c_data_ff [2][TCA_C_LINES];
  logic [3:0] c_val_ff [2][TCA_C_LINES];
  logic c_lru_ff [TCA_C_LINES];
  logic [6:0] flush_idx_ff;

  // Bus handshake state
  logic aw_got_ff;
  logic w_got_ff;
  logic [4:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;

  // Merge write data into a word under byte strobes
  function automatic logic [31:0] tca_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : tca_merge

  // One attribute pair against a stored bit
  function automatic logic tca_attr_match(input logic [1:0] pair, input logic bit_val);
    return bit_val ? pair[1] : pair[0];
  endfunction : tca_attr_match

  // Way picked by a three-bit tree pseudo-LRU
  function automatic logic [1:0] tca_plru_victim(input logic [2:0] t);
    return t[0] ? {1'b1, t[2]} : {1'b0, t[1]};
  endfunction : tca_plru_victim

  // Tree update that points away from the way just used
  function automatic logic [2:0] tca_plru_touch(input logic [2:0] t, input logic [1:0] w);
    logic [2:0] r;
    r = t;
    r[0] = ~w[1];
    if (w[1]) begin
      r[2] = ~w[0];
    end else begin
      r[1] = ~w[0];
    end
    return r;
  endfunction : tca_plru_touch

  // Offset inside the register window and word aligned
  function automatic logic tca_addr_ok(input logic [4:0] a);
    return (a <= TCA_OFF_STATUS) && (a[1:0] == 2'h0);
  endfunction : tca_addr_ok

  // Decoded command fields
  logic [19:0] cmd_lin;
  logic [2:0] set_idx;
  logic [1:0] d_pair;
  logic [1:0] u_pair;
  logic [1:0] r_pair;
  logic [3:0] hit_vec;
  logic [1:0] hit_way;
  logic [2:0] hit_cnt;
  logic [1:0] wr_way;
  logic [6:0] c_line;
  logic c_way;

  // Set index from low linear page bits; tag compare over the full page number
  assign cmd_lin = tlb_test_command_ff[31:TCA_LIN_LO];
  assign set_idx = cmd_lin[2:0];
  assign d_pair = tlb_test_command_ff[TCA_CMD_D_HI -: 2];
  assign u_pair = tlb_test_command_ff[TCA_CMD_U_HI -: 2];
  assign r_pair = tlb_test_command_ff[TCA_CMD_R_HI -: 2];
  assign c_line = cache_test_control_ff[TCA_CC_LINE_LO +: 7];
  assign c_way = cache_test_control_ff[TCA_CC_WAY];

  // Associative search of the four ways
  always_comb begin
    hit_vec = 4'h0;
    hit_way = 2'h0;
    hit_cnt = 3'h0;
    for (int w = 0; w < TCA_TLB_WAYS; w++) begin
      if (tlb_val_ff[w][set_idx] && tlb_test_command_ff[TCA_CMD_V]
          && tlb_lin_ff[w][set_idx] == cmd_lin
          && tca_attr_match(d_pair, tlb_attr_ff[w][set_idx][2])
          && tca_attr_match(u_pair, tlb_attr_ff[w][set_idx][1])
          && tca_attr_match(r_pair, tlb_attr_ff[w][set_idx][0])) begin
        hit_vec[w] = 1'b1;
        hit_way = 2'(w);
        hit_cnt = hit_cnt + 3'h1;
      end
    end
  end

  // Write target: forced way or pseudo-LRU choice
  assign wr_way = tlb_test_data_ff[TCA_TD_HIT] ? tlb_test_data_ff[TCA_TD_WAY_LO +: 2]
                                               : tca_plru_victim(tlb_plru_ff[set_idx]);

  // Exactly one matching way; several matches count as a miss
  logic tlb_hit;
  assign tlb_hit = (hit_cnt == 3'h1);

  // Cache operation code held in the control register
  logic [1:0] c_op;
  assign c_op = cache_test_control_ff[1:0];

  // Bus write waiting to be taken, address and data both held; taken only when idle
  logic wr_fire;
  assign wr_fire = aw_got_ff && w_got_ff && !s_axi_bvalid;

  // Address and data may arrive in either order; each is held until both are here
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      aw_addr_ff <= 5'h00;
      w_data_ff <= TCA_RST_WORD;
      w_strb_ff <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= TCA_RESP_OK;
    end else begin
      // Nothing new is taken while a response waits, so one write is ever in flight
      s_axi_awready <= !aw_got_ff && !s_axi_awready && s_axi_awvalid && !s_axi_bvalid;
      s_axi_wready <= !w_got_ff && !s_axi_wready && s_axi_wvalid && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr[4:0];
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      // Writes wait while an operation runs, so registers never change under it
      if (wr_fire && state_ff == TCA_IDLE) begin
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= tca_addr_ok(aw_addr_ff) ? TCA_RESP_OK : TCA_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic do_write;
  assign do_write = wr_fire && state_ff == TCA_IDLE;

  // Operation sequencer; one cycle per buffer or cache op, 128 for a flush
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= TCA_IDLE;
      flush_idx_ff <= 7'h00;
    end else begin
      case (state_ff)
        TCA_IDLE: begin
          if (do_write && aw_addr_ff == TCA_OFF_TLB_CMD) begin
            state_ff <= TCA_TLB_OP;
          end else if (do_write && aw_addr_ff == TCA_OFF_C_CTRL && w_strb_ff[0]
                       && w_data_ff[1:0] != TCA_COP_NONE) begin
            state_ff <= (w_data_ff[1:0] == TCA_COP_FLUSH) ? TCA_FLUSH : TCA_C_OP;
            flush_idx_ff <= 7'h00;
          end
        end
        TCA_TLB_OP: state_ff <= TCA_IDLE;
        TCA_C_OP: state_ff <= TCA_IDLE;
        TCA_FLUSH: begin
          flush_idx_ff <= flush_idx_ff + 7'h01;
          if (flush_idx_ff == 7'(TCA_C_LINES - 1)) begin
            state_ff <= TCA_IDLE;
          end
        end
        default: state_ff <= TCA_IDLE;
      endcase
    end
  end

  // Translation test registers: bus writes and lookup results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tlb_test_command_ff <= TCA_RST_WORD;
      tlb_test_data_ff <= TCA_RST_WORD;
    end else if (do_write && aw_addr_ff == TCA_OFF_TLB_CMD) begin
      tlb_test_command_ff <= tca_merge(tlb_test_command_ff, w_data_ff, w_strb_ff);
    end else if (do_write && aw_addr_ff == TCA_OFF_TLB_DATA) begin
      tlb_test_data_ff <= tca_merge(tlb_test_data_ff, w_data_ff, w_strb_ff);
    end else if (state_ff == TCA_TLB_OP && tlb_test_command_ff[TCA_CMD_OP]) begin
      tlb_test_data_ff[TCA_TD_HIT] <= tlb_hit;
      if (tlb_hit) begin
        tlb_test_data_ff[31:TCA_LIN_LO] <= tlb_page_ff[hit_way][set_idx];
        tlb_test_data_ff[TCA_TD_PCD] <= tlb_pc_ff[hit_way][set_idx][1];
        tlb_test_data_ff[TCA_TD_PWT] <= tlb_pc_ff[hit_way][set_idx][0];
        tlb_test_data_ff[TCA_TD_LRU_LO +: 3] <= tlb_plru_ff[set_idx];
        tlb_test_data_ff[TCA_TD_WAY_LO +: 2] <= hit_way;
        tlb_test_command_ff[TCA_CMD_D_HI -: 2] <= tlb_attr_ff[hit_way][set_idx][2] ? 2'h2 : 2'h1;
        tlb_test_command_ff[TCA_CMD_U_HI -: 2] <= tlb_attr_ff[hit_way][set_idx][1] ? 2'h2 : 2'h1;
        tlb_test_command_ff[TCA_CMD_R_HI -: 2] <= tlb_attr_ff[hit_way][set_idx][0] ? 2'h2 : 2'h1;
      end
    end
  end

  // Translation buffer arrays; entries come out of reset invalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int w = 0; w < TCA_TLB_WAYS; w++) begin
        for (int s = 0; s < TCA_TLB_SETS; s++) begin
          tlb_val_ff[w][s] <= 1'b0;
          tlb_lin_ff[w][s] <= 20'h00000;
          tlb_page_ff[w][s] <= 20'h00000;
          tlb_attr_ff[w][s] <= 3'h0;
          tlb_pc_ff[w][s] <= 2'h0;
        end
      end
      for (int s = 0; s < TCA_TLB_SETS; s++) begin
        tlb_plru_ff[s] <= 3'h0;
      end
    end else if (state_ff == TCA_TLB_OP) begin
      if (!tlb_test_command_ff[TCA_CMD_OP]) begin
        tlb_lin_ff[wr_way][set_idx] <= cmd_lin;
        tlb_val_ff[wr_way][set_idx] <= tlb_test_command_ff[TCA_CMD_V];
        tlb_page_ff[wr_way][set_idx] <= tlb_test_data_ff[31:TCA_LIN_LO];
        tlb_pc_ff[wr_way][set_idx] <= tlb_test_data_ff[TCA_TD_PCD -: 2];
        // Undefined pairs 00 and 11 take the high bit: a simple, repeatable choice
        tlb_attr_ff[wr_way][set_idx] <= {d_pair[1], u_pair[1], r_pair[1]};
        tlb_plru_ff[set_idx] <= tca_plru_touch(tlb_plru_ff[set_idx], wr_way);
      end else if (tlb_hit) begin
        tlb_plru_ff[set_idx] <= tca_plru_touch(tlb_plru_ff[set_idx], hit_way);
      end
    end
  end

  // Cache test registers: bus writes and cache read results
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cache_test_data_ff <= TCA_RST_WORD;
      cache_test_tag_status_ff <= TCA_RST_WORD;
      cache_test_control_ff <= TCA_RST_WORD;
    end else if (do_write && aw_addr_ff == TCA_OFF_C_DATA) begin
      cache_test_data_ff <= tca_merge(cache_test_data_ff, w_data_ff, w_strb_ff);
    end else if (do_write && aw_addr_ff == TCA_OFF_C_TAG) begin
      cache_test_tag_status_ff <= tca_merge(cache_test_tag_status_ff, w_data_ff, w_strb_ff);
    end else if (do_write && aw_addr_ff == TCA_OFF_C_CTRL) begin
      cache_test_control_ff <= tca_merge(cache_test_control_ff, w_data_ff, w_strb_ff);
    end else if (state_ff == TCA_C_OP && c_op == TCA_COP_READ) begin
      cache_test_data_ff <= c_data_ff[c_way][c_line];
      cache_test_tag_status_ff[31:TCA_CT_TAG_LO] <= c_tag_ff[c_way][c_line];
      cache_test_tag_status_ff[TCA_CT_LRU] <= c_lru_ff[c_line];
      cache_test_tag_status_ff[TCA_CT_VAL_LO +: 4] <= c_val_ff[c_way][c_line];
    end
  end

  // Cache arrays; the flush clears one line per cycle in both ways
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int l = 0; l < TCA_C_LINES; l++) begin
        c_val_ff[0][l] <= 4'h0;
        c_val_ff[1][l] <= 4'h0;
        c_lru_ff[l] <= 1'b0;
      end
    end else if (state_ff == TCA_FLUSH) begin
      c_val_ff[0][flush_idx_ff] <= 4'h0;
      c_val_ff[1][flush_idx_ff] <= 4'h0;
    end else if (state_ff == TCA_C_OP && c_op == TCA_COP_WRITE) begin
      c_val_ff[c_way][c_line] <= cache_test_tag_status_ff[TCA_CT_VAL_LO +: 4];
      c_lru_ff[c_line] <= ~c_way; // Replacement bit points at the other way
    end
  end

  // Data and tag stores have no reset; only valids matter after reset
  always_ff @(posedge aclk) begin
    if (state_ff == TCA_C_OP && c_op == TCA_COP_WRITE) begin
      c_data_ff[c_way][c_line] <= cache_test_data_ff;
      c_tag_ff[c_way][c_line] <= cache_test_tag_status_ff[31:TCA_CT_TAG_LO];
    end
  end

  // Read channel: one read at a time, answered two cycles after arvalid
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= TCA_RST_WORD;
      s_axi_rresp <= TCA_RESP_OK;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= TCA_RESP_OK;
        case (s_axi_araddr[4:0])
          TCA_OFF_TLB_CMD: s_axi_rdata <= tlb_test_command_ff;
          TCA_OFF_TLB_DATA: s_axi_rdata <= tlb_test_data_ff;
          TCA_OFF_C_DATA: s_axi_rdata <= cache_test_data_ff;
          TCA_OFF_C_TAG: s_axi_rdata <= cache_test_tag_status_ff;
          TCA_OFF_C_CTRL: s_axi_rdata <= cache_test_control_ff;
          TCA_OFF_STATUS: s_axi_rdata <= {30'h0, state_ff};
          default: begin
            s_axi_rdata <= TCA_RST_WORD;
            s_axi_rresp <= TCA_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule : tca_top

/* File: dv/tca_top_sva.sv */
`timescale 1ns/10ps
module tca_top_sva
  import tca_pkg::*;
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset
  input wire logic [31:0] s_axi_awaddr, // AW
  input wire logic s_axi_awvalid, // AW
  input wire logic s_axi_awready, // AW
  input wire logic [31:0] s_axi_wdata, // W
  input wire logic [3:0] s_axi_wstrb, // W
  input wire logic s_axi_wvalid, // W
  input wire logic s_axi_wready, // W
  input wire logic [1:0] s_axi_bresp, // B
  input wire logic s_axi_bvalid, // B
  input wire logic s_axi_bready, // B
  input wire logic [31:0] s_axi_araddr, // AR
  input wire logic s_axi_arvalid, // AR
  input wire logic s_axi_arready, // AR
  input wire logic [31:0] s_axi_rdata, // R
  input wire logic [1:0] s_axi_rresp, // R
  input wire logic s_axi_rvalid, // R
  input wire logic s_axi_rready // R
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Read path: fixed answer time, data held, bad address refused
  property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
  property p_rd_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data not held");
  property p_rd_err; s_axi_arvalid && s_axi_arready && (s_axi_araddr[4:0] > 5'h14 || s_axi_araddr[1:0] != 2'h0)
    |=> s_axi_rresp == TCA_RESP_SLVERR; endproperty
  a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
  property p_ar_wait; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_wait: assert property (p_ar_wait) else $error("address taken during answer");
  // Write path: bounded answer, held until taken, no overlap
  property p_wr_ans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:200] s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
  property p_wr_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write response not held");
  property p_wr_drop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_wr_drop: assert property (p_wr_drop) else $error("write response stuck");
  property p_wr_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_block: assert property (p_wr_block) else $error("write taken during answer");
endmodule : tca_top_sva

bind tca_top tca_top_sva tca_top_sva_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

/* File: dv/tca_top_tb.sv */
`timescale 1ns/10ps
module tca_top_tb
  import tca_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int num_errors = 0, n_checks = 0, cyc = 0;
  integer seed = 32'hF17C;
  logic [19:0] lin [5], page [5];
  logic [4:0] at [5];
  logic [22:0] ctag [4];
  logic [3:0] cval [4];
  logic [31:0] cdat [4];
  logic [6:0] cline [4];
  logic [2:0] tree = 3'h0;

  tca_top tca_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // 125 MHz clock
  always #4 aclk = ~aclk;

  // Hang guard, far above the roughly nine hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      final_report();
    end
  end

  // Register word images built from field values
  function automatic logic [1:0] pr(input logic b);
    return b ? 2'h2 : 2'h1;
  endfunction : pr
  function automatic logic [31:0] cmd(input logic [19:0] l, input logic v, input logic [5:0] p, input logic o);
    return {l, v, p, 4'h0, o};
  endfunction : cmd
  function automatic logic [31:0] tdat(input logic [19:0] p, input logic [1:0] cw, input logic f, input logic [1:0] w);
    return {p, cw, 5'h0, f, w, 2'h0};
  endfunction : tdat
  // Replacement tree of the test set: bit 0 picks a half (1 = ways 2-3), bits 1 and 2 a way in it
  function automatic logic [2:0] touch(input logic [2:0] t, input logic [1:0] w);
    logic [2:0] n;
    n = t;
    n[0] = ~w[1];
    if (w[1]) n[2] = ~w[0];
    else n[1] = ~w[0];
    return n;
  endfunction : touch

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input logic [31:0] m, input string s);
    n_checks++;
    if ((g & m) !== (e & m)) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : chk

  // Ready sampled at the falling edge, since it only moves on rising edges; bready waits for bvalid
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ha, hw, hb, vb;
    s_axi_awaddr <= {27'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      vb = s_axi_bvalid;
      hb = s_axi_bvalid & s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (vb && !hb) s_axi_bready <= 1'b1;
    end while (!hb);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ha, hb, vb;
    s_axi_araddr <= {27'h0, a};
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      vb = s_axi_rvalid;
      hb = s_axi_rvalid & s_axi_rready;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (vb && !hb) s_axi_rready <= 1'b1;
    end while (!hb);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Start an operation and poll the status word until idle
  task automatic op(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] s;
    logic [1:0] r;
    wr(a, d, r);
    s = 32'h1;
    while (s[1:0] !== 2'h0) rd(TCA_OFF_STATUS, s, r);
  endtask : op

  task automatic lk(input logic [19:0] l, input logic [5:0] p, output logic [31:0] d, output logic [31:0] c);
    logic [1:0] r;
    wr(TCA_OFF_TLB_DATA, 32'h0, r);
    op(TCA_OFF_TLB_CMD, cmd(l, 1'b1, p, 1'b1));
    rd(TCA_OFF_TLB_DATA, d, r);
    rd(TCA_OFF_TLB_CMD, c, r);
  endtask : lk

  // Cache line read back; a flush leaves tag and data but no valids
  task automatic crd(input int k, input logic fl);
    logic [31:0] d;
    logic [1:0] r;
    wr(TCA_OFF_C_DATA, 32'h0, r);
    wr(TCA_OFF_C_TAG, 32'h0, r);
    op(TCA_OFF_C_CTRL, {21'h0, cline[k], 1'b0, k[0], TCA_COP_READ});
    rd(TCA_OFF_C_DATA, d, r);
    chk(d, cdat[k], 32'hFFFFFFFF, "cache data");
    rd(TCA_OFF_C_TAG, d, r);
    chk(d, {ctag[k], 1'b0, ~k[0], fl ? 4'h0 : cval[k], 3'h0}, fl ? 32'hFFFFFE78 : 32'hFFFFFEF8, "cache tag");
  endtask : crd

  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // Main sequence
  initial begin
    logic [31:0] d, c, e;
    logic [1:0] r, vw;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rd(5'(i * 4), d, r);
      chk(d, TCA_RST_WORD, 32'hFFFFFFFF, "reset word");
    end
    rd(5'h18, d, r);
    chk({30'h0, r}, {30'h0, TCA_RESP_SLVERR}, 32'h3, "unmapped read");
    wr(5'h1C, 32'hFFFFFFFF, r);
    chk({30'h0, r}, {30'h0, TCA_RESP_SLVERR}, 32'h3, "unmapped write");
    $display("test reset done");
    // Forced way writes into one set, then lookups
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      c = $random(seed);
      lin[i] = {i[1:0], d[14:0], 3'h5};
      page[i] = c[31:12];
      at[i] = c[4:0];
      wr(TCA_OFF_TLB_DATA, tdat(page[i], at[i][1:0], 1'b1, i[1:0]), r);
      op(TCA_OFF_TLB_CMD, cmd(lin[i], 1'b1, {pr(at[i][4]), pr(at[i][3]), pr(at[i][2])}, 1'b0));
      tree = touch(tree, i[1:0]);
    end
    for (int i = 0; i < 4; i++) begin
      lk(lin[i], 6'h3F, d, c);
      chk(d, tdat(page[i], at[i][1:0], 1'b1, i[1:0]), 32'hFFFFFC1C, "lookup data");
      chk({29'h0, d[9:7]}, {29'h0, tree}, 32'h7, "lookup history");
      tree = touch(tree, i[1:0]);
      e = cmd(lin[i], 1'b1, {pr(at[i][4]), pr(at[i][3]), pr(at[i][2])}, 1'b1);
      chk(c, e, 32'hFFFFFFE1, "lookup command");
    end
    // Attribute mismatch and a never-matching pair both miss
    lk(lin[0], {pr(~at[0][4]), 4'hF}, d, c);
    chk(d, 32'h0, 32'hFFFFFC10, "attribute miss");
    lk(lin[0], 6'h3C, d, c);
    chk(d, 32'h0, 32'hFFFFFC10, "pair 00 miss");
    // Invalidate one entry
    wr(TCA_OFF_TLB_DATA, tdat(page[2], 2'h0, 1'b1, 2'h2), r);
    op(TCA_OFF_TLB_CMD, cmd(lin[2], 1'b0, 6'h15, 1'b0));
    tree = touch(tree, 2'h2);
    lk(lin[2], 6'h3F, d, c);
    chk(d, 32'h0, 32'h10, "invalidated miss");
    // Replacement chosen by the design
    lin[4] = lin[0] ^ 20'h08000;
    page[4] = 20'($random(seed));
    vw = tree[0] ? {1'b1, tree[2]} : {1'b0, tree[1]};
    wr(TCA_OFF_TLB_DATA, tdat(page[4], 2'h3, 1'b0, 2'h0), r);
    op(TCA_OFF_TLB_CMD, cmd(lin[4], 1'b1, 6'h15, 1'b0));
    lk(lin[4], 6'h3F, d, c);
    chk(d, tdat(page[4], 2'h3, 1'b1, vw), 32'hFFFFFC1C, "replaced hit");
    $display("test tlb done");
    // Cache line writes, valids before data
    for (int k = 0; k < 4; k++) begin
      d = $random(seed);
      cline[k] = {d[4:0], k[1:0]};
      ctag[k] = d[31:9];
      cval[k] = d[8:5];
      cdat[k] = $random(seed);
      wr(TCA_OFF_C_TAG, {ctag[k], 1'b0, d[0], cval[k], 3'h0}, r);
      wr(TCA_OFF_C_DATA, cdat[k], r);
      op(TCA_OFF_C_CTRL, {21'h0, cline[k], 1'b0, k[0], TCA_COP_WRITE});
    end
    for (int k = 0; k < 4; k++) crd(k, 1'b0);
    // Operation code zero does nothing
    wr(TCA_OFF_C_DATA, 32'hA5A5A5A5, r);
    op(TCA_OFF_C_CTRL, {21'h0, cline[0], 1'b0, 1'b0, TCA_COP_NONE});
    rd(TCA_OFF_C_DATA, d, r);
    chk(d, 32'hA5A5A5A5, 32'hFFFFFFFF, "no-op");
    op(TCA_OFF_C_CTRL, {30'h0, TCA_COP_FLUSH});
    for (int k = 0; k < 4; k++) crd(k, 1'b1);
    $display("test cache done");
    final_report();
  end
endmodule : tca_top_tb
